// File: verilog/dbh_host.sv
// Host controller driving the DMA burst handshake pins
`timescale 1ns/1ps
`default_nettype none
module dbh_host
    import dbh_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_start,          // Start a burst, pulse
    input wire logic i_ultra,          // 1 Ultra DMA, 0 Multiword
    input wire logic i_dir_in,         // 1 data-in, 0 data-out
    input wire logic i_stop,           // Host wants to end the burst
    input wire logic i_out_valid,      // Write word offered
    input wire logic [15:0] i_out_data,
    output logic o_out_ready,          // Write word taken
    output logic o_in_valid,           // Read word offered
    output logic [15:0] o_in_data,
    input wire logic i_in_ready,       // Read word taken by user
    output logic o_busy,               // Burst in progress
    input wire logic i_dmarq,          // Device request pin
    input wire logic i_iordy,          // Device ready or strobe pin
    input wire logic [15:0] i_dd,      // Data bus input
    output logic [15:0] o_dd,          // Data bus output
    output logic o_dd_oe,              // Data bus drive enable
    output logic o_dmack_n,            // Acknowledge, active low
    output logic o_dior_n,             // Read strobe / host ready / stop side
    output logic o_diow_n,             // Write strobe / stop
    output logic o_hstrobe             // Host strobe for data-out
);
    // Pin synchronisers
    logic [2:0] s1_ff, s2_ff, s3_ff;
    logic [15:0] d1_ff, d2_ff;
    always_ff @(posedge i_clk_sys) begin
        s1_ff <= {i_dmarq, i_iordy, 1'b0};
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        d1_ff <= i_dd;
        d2_ff <= d1_ff;
    end
    logic rq, strb, strb_edge;
    assign rq = s2_ff[2];
    assign strb = s2_ff[1];
    assign strb_edge = s2_ff[1] ^ s3_ff[1];
    // Read-side buffer
    dbh_buf_if rin ();
    dbh_buf_if rout ();
    dbh_skid u_skid (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .in_p(rin.snk),
        .out_p(rout.src)
    );
    // State registers
    dbh_state_t st_ff, nxt_st;
    logic [7:0] cnt_ff, nxt_cnt;
    logic ack_ff, nxt_ack, rd_ff, nxt_rd, wr_ff, nxt_wr, hs_ff, nxt_hs;
    logic oe_ff, nxt_oe, ul_ff, nxt_ul, din_ff, nxt_din, pend_ff, nxt_pend;
    logic [15:0] dd_ff, nxt_dd, crc_ff, nxt_crc, cap_ff, nxt_cap;
    logic cap_v_ff, nxt_cap_v, ordy_ff, nxt_ordy;
    // CRC update of one word
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction
    // Buffer hookup
    assign rin.valid = cap_v_ff;
    assign rin.data = cap_ff;
    // Next-state logic of the burst engine
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = (cnt_ff != CNT_ZERO) ? cnt_ff - 8'd1 : CNT_ZERO;
        nxt_ack = ack_ff;
        nxt_rd = rd_ff;
        nxt_wr = wr_ff;
        nxt_hs = hs_ff;
        nxt_oe = oe_ff;
        nxt_ul = ul_ff;
        nxt_din = din_ff;
        nxt_pend = pend_ff;
        nxt_dd = dd_ff;
        nxt_crc = crc_ff;
        nxt_cap = cap_ff;
        nxt_cap_v = cap_v_ff && !rin.ready;
        nxt_ordy = 1'b0;
        if (i_stop && st_ff != DBH_IDLE) begin
            nxt_pend = 1'b1;
        end
        case (st_ff)
            DBH_IDLE: begin
                nxt_pend = 1'b0;
                // Start is taken only while request is present, else ignored
                if (i_start && rq) begin
                    nxt_ul = i_ultra;
                    nxt_din = i_dir_in;
                    nxt_wr = i_ultra;  // Stop held asserted until envelope ends
                    nxt_hs = 1'b1;     // Strobe parked high before ack
                    nxt_crc = CRC_SEED;
                    nxt_cnt = 8'(C_ZAH);
                    nxt_st = i_ultra ? DBH_U_ACK : DBH_MW_SETUP;
                end
            end
            DBH_MW_SETUP: begin
                nxt_ack = 1'b1;
                if (cnt_ff == CNT_ZERO) begin
                    if (!rq || pend_ff) begin
                        nxt_cnt = 8'(C_J);
                        nxt_st = DBH_MW_HOLD;
                    end else if (din_ff || i_out_valid) begin
                        nxt_oe = !din_ff;
                        nxt_dd = i_out_data;
                        nxt_rd = din_ff;
                        nxt_wr = !din_ff;
                        nxt_cnt = 8'(C_D);
                        nxt_st = DBH_MW_PULSE;
                    end
                end
            end
            DBH_MW_PULSE: begin
                if (cnt_ff == CNT_ZERO && (!din_ff || rin.ready)) begin
                    // Word moves at pulse negation
                    nxt_rd = 1'b0;
                    nxt_wr = 1'b0;
                    nxt_cap = d2_ff;
                    nxt_cap_v = din_ff;
                    nxt_ordy = !din_ff;
                    nxt_cnt = 8'(C_K);
                    nxt_st = DBH_MW_RECOV;
                end
            end
            DBH_MW_RECOV: begin
                nxt_oe = 1'b0;
                // Device may end by dropping request
                if (cnt_ff == CNT_ZERO) begin
                    nxt_st = DBH_MW_SETUP;
                end
            end
            DBH_MW_HOLD: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_ack = 1'b0;
                    nxt_cnt = 8'(C_ZAH);
                    nxt_st = DBH_U_REL;
                end
            end
            DBH_U_ACK: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_ack = 1'b1;
                    nxt_cnt = 8'(C_ENV);
                    nxt_st = DBH_U_ENV;
                end
            end
            DBH_U_ENV: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_wr = 1'b0;           // Stop negated
                    nxt_rd = din_ff;         // Host ready asserted in data-in only
                    nxt_oe = !din_ff;
                    nxt_hs = 1'b1;
                    nxt_cnt = 8'(C_HALF);
                    nxt_st = DBH_U_RUN; // data next; device strobes in data-in, host in data-out
                end
            end
            DBH_U_RUN: begin
                if (!rq) begin
                    nxt_cnt = 8'(C_MLI);
                    nxt_st = DBH_U_CRC;
                end else if (din_ff) begin
                    // Capture a word on each strobe edge
                    if (strb_edge) begin
                        nxt_cap = d2_ff;
                        nxt_cap_v = 1'b1;
                        nxt_crc = crc_upd(crc_ff, d2_ff);
                    end
                    // Pause by dropping ready when buffer fills
                    nxt_rd = rin.ready && !pend_ff;
                    if (pend_ff && !rd_ff) begin
                        nxt_cnt = 8'(C_RP);
                        nxt_st = DBH_U_SS;
                    end
                end else if (cnt_ff == CNT_ZERO) begin
                    if (pend_ff || !i_out_valid) begin
                        nxt_cnt = 8'(C_SS);
                        nxt_st = DBH_U_SS;
                    end else if (strb) begin
                        // Device ready held; paced toggle
                        nxt_dd = i_out_data;
                        nxt_hs = !hs_ff;
                        nxt_ordy = 1'b1;
                        nxt_crc = crc_upd(crc_ff, i_out_data);
                        nxt_cnt = 8'(C_HALF);
                    end
                end
            end
            DBH_U_SS: begin
                if (din_ff && strb_edge) begin
                    nxt_cap = d2_ff;
                    nxt_cap_v = 1'b1;
                    nxt_crc = crc_upd(crc_ff, d2_ff);
                end
                if (cnt_ff == CNT_ZERO) begin
                    nxt_wr = 1'b1; // Stop asserted
                end
                if (!rq && wr_ff) begin
                    nxt_cnt = 8'(C_MLI);
                    nxt_st = DBH_U_CRC;
                end
            end
            DBH_U_CRC: begin
                nxt_wr = 1'b1;
                nxt_hs = 1'b1;
                nxt_oe = 1'b1;
                nxt_dd = crc_ff;
                if (cnt_ff == CNT_ZERO) begin
                    nxt_cnt = 8'(C_CVS);
                    nxt_st = DBH_U_CVH;
                    nxt_pend = 1'b1;
                end
            end
            DBH_U_CVH: begin
                if (cnt_ff == CNT_ZERO && ack_ff) begin
                    nxt_ack = 1'b0;
                    nxt_pend = 1'b0;
                    nxt_cnt = 8'(C_CVH);
                end else if (cnt_ff == CNT_ZERO) begin
                    nxt_oe = 1'b0;
                    nxt_rd = 1'b0;
                    // Stop stays asserted: it is the idle level of the pin
                    nxt_hs = 1'b0;
                    nxt_cnt = 8'(C_ZAH);
                    nxt_st = DBH_U_REL;
                end
            end
            default: begin // DBH_U_REL
                nxt_oe = 1'b0;
                if (cnt_ff == CNT_ZERO) begin
                    nxt_st = DBH_IDLE;
                end
            end
        endcase
    end
    // Register the burst engine
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_ff <= DBH_IDLE;
            cnt_ff <= CNT_ZERO;
            ack_ff <= 1'b0;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            hs_ff <= 1'b0;
            oe_ff <= 1'b0;
            ul_ff <= 1'b0;
            din_ff <= 1'b0;
            pend_ff <= 1'b0;
            dd_ff <= WORD_ZERO;
            crc_ff <= CRC_SEED;
            cap_ff <= WORD_ZERO;
            cap_v_ff <= 1'b0;
            ordy_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ack_ff <= nxt_ack;
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            hs_ff <= nxt_hs;
            oe_ff <= nxt_oe;
            ul_ff <= nxt_ul;
            din_ff <= nxt_din;
            pend_ff <= nxt_pend;
            dd_ff <= nxt_dd;
            crc_ff <= nxt_crc;
            cap_ff <= nxt_cap;
            cap_v_ff <= nxt_cap_v;
            ordy_ff <= nxt_ordy;
        end
    end
    // Registered user-side outputs
    logic iv_ff, busy_ff;
    logic [15:0] id_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            iv_ff <= 1'b0;
            id_ff <= WORD_ZERO;
            busy_ff <= 1'b0;
        end else begin
            if (rout.ready) begin
                iv_ff <= rout.valid;
                id_ff <= rout.data;
            end
            busy_ff <= (nxt_st != DBH_IDLE);
        end
    end
    // Head word leaves the buffer only into a free output slot
    assign rout.ready = !iv_ff || i_in_ready;
    // Pin mapping; multiword strobes are active low
    assign o_dmack_n = !ack_ff;
    assign o_dior_n = ul_ff ? !rd_ff : !rd_ff;
    assign o_diow_n = ul_ff ? wr_ff : !wr_ff;
    assign o_hstrobe = hs_ff;
    assign o_dd = dd_ff;
    assign o_dd_oe = oe_ff;
    assign o_out_ready = ordy_ff;
    assign o_in_valid = iv_ff;
    assign o_in_data = id_ff;
    assign o_busy = busy_ff;
endmodule // dbh_host
`default_nettype wire

// File: verilog/dbh_pkg.sv
// Package with timing constants and types of the DMA burst host controller
package dbh_pkg;
    localparam int CLK_NS = 100;                 // System clock period in ns
    localparam int T_ACK_NS = 20;                // Acknowledge setup and hold, min
    localparam int T_ENV_MIN_NS = 20;            // Envelope, min
    localparam int T_MLI_NS = 20;                // Interlock with minimum
    localparam int T_ZAH_NS = 20;                // Wait after release before driving
    localparam int T_CVS_NS = 70;                // CRC setup before acknowledge negation
    localparam int T_CVH_NS = 10;                // CRC hold after acknowledge negation
    localparam int T_RP_NS = 160;                // Ready to pause, min
    localparam int T_SS_NS = 50;                 // Last strobe to stop, min
    localparam int T_2CYC_NS = 240;              // Typical two-cycle time of strobe
    localparam int T_CYC_NS = 112;               // Strobe edge to edge, min
    localparam int T_J_NS = 20;                  // Read/write pulse to acknowledge hold
    localparam int T_D_NS = 215;                 // Multiword pulse width, min
    localparam int T_K_NS = 215;                 // Multiword negated width, min
    // Least times rounded up to whole cycles, at least one
    localparam int C_ACK = (T_ACK_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_ENV = (T_ENV_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_MLI = (T_MLI_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_ZAH = (T_ZAH_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CVS = (T_CVS_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CVH = (T_CVH_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_SS = (T_SS_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_HALF = (T_2CYC_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int C_J = (T_J_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_D = (T_D_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_K = (T_K_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] CRC_SEED = 16'h4ABA; // CRC start value
    localparam logic [15:0] CRC_POLY = 16'h1021; // CRC polynomial
    typedef enum {
        DBH_IDLE, DBH_MW_SETUP, DBH_MW_PULSE, DBH_MW_RECOV, DBH_MW_HOLD,
        DBH_U_ACK, DBH_U_ENV, DBH_U_RUN, DBH_U_SS, DBH_U_CRC, DBH_U_CVH, DBH_U_REL
    } dbh_state_t;
endpackage

// File: verilog/dbh_buf_if.sv
// Interface carrying a valid/ready word stream between modules
`timescale 1ns/1ps
`default_nettype none
interface dbh_buf_if;
    logic valid;   // Word offered
    logic ready;   // Word accepted
    logic [15:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // dbh_buf_if
`default_nettype wire

// File: verilog/dbh_skid.sv
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dbh_skid
    import dbh_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    dbh_buf_if.snk in_p,
    dbh_buf_if.src out_p
);
    logic [15:0] mem_ff [2];        // Storage
    logic [15:0] nxt_mem [2];
    logic rd_ff, nxt_rd;            // Read pointer
    logic wr_ff, nxt_wr;            // Write pointer
    logic [1:0] cnt_ff, nxt_cnt;    // Fill level
    // Next state of the buffer
    always_comb begin
        logic push;
        logic pop;
        push = in_p.valid && in_p.ready;
        pop = out_p.valid && out_p.ready;
        nxt_mem = mem_ff;
        nxt_rd = rd_ff;
        nxt_wr = wr_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wr_ff] = in_p.data;
            nxt_wr = ~wr_ff;
        end
        if (pop) begin
            nxt_rd = ~rd_ff;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'd1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'd1;
        end
    end
    // Register the buffer
    always_ff @(posedge i_clk_sys) begin
        mem_ff <= nxt_mem;
        if (i_reset) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            cnt_ff <= 2'd0;
        end else begin
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            cnt_ff <= nxt_cnt;
        end
    end
    assign in_p.ready = (cnt_ff != 2'd2);  // Honest full
    assign out_p.valid = (cnt_ff != 2'd0); // Honest empty
    assign out_p.data = mem_ff[rd_ff];
endmodule // dbh_skid
`default_nettype wire

// File: verification/dbh_properties.sv
// Checker of the handshake pin timing of the DMA burst host
`timescale 1ns/1ps
`default_nettype none
module dbh_properties (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ultra,
    input wire logic i_dir_in,
    input wire logic i_iordy,
    input wire logic [15:0] o_dd,
    input wire logic o_dd_oe,
    input wire logic o_dmack_n,
    input wire logic o_dior_n,
    input wire logic o_diow_n,
    input wire logic o_hstrobe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // Strobes and stop only fall a cycle after acknowledge
    property p_env;
        ($fell(o_diow_n) || $fell(o_dior_n)) |-> !o_dmack_n && !$past(o_dmack_n);
    endproperty
    a_env: assert property (p_env) else $error("strobe moved outside ack");
    // Strobes and stop still around acknowledge edges
    property p_ack_stable;
        $changed(o_dmack_n) |-> $stable(o_diow_n) && $stable(o_dior_n);
    endproperty
    a_ack_stable: assert property (p_ack_stable) else $error("pins moved with ack");
    // Multiword ack drops only after pulse ended
    property p_mw_end;
        $rose(o_dmack_n) && !i_ultra |->
            o_dior_n && o_diow_n && $past(o_dior_n) && $past(o_diow_n);
    endproperty
    a_mw_end: assert property (p_mw_end) else $error("ack ended inside pulse");
    // Check word driven and steady as ack negates
    property p_crc;
        $rose(o_dmack_n) && i_ultra |-> o_dd_oe && $stable(o_dd);
    endproperty
    a_crc: assert property (p_crc) else $error("check word not held");
    // Opposite strobe edges at least two cycles apart
    property p_opp;
        $changed(o_hstrobe) |=> $stable(o_hstrobe);
    endproperty
    a_opp: assert property (p_opp) else $error("strobe edges too close");
    // Rising strobe edges at least three cycles apart
    property p_same;
        $rose(o_hstrobe) |=> (!$rose(o_hstrobe)) [*2];
    endproperty
    a_same: assert property (p_same) else $error("rising strobes too close");
    // Stop not raised in the cycle of a strobe edge
    property p_ss;
        $rose(o_diow_n) && i_ultra && !o_dmack_n |-> $stable(o_hstrobe);
    endproperty
    a_ss: assert property (p_ss) else $error("stop with strobe edge");
    // Strobe halts once device ready stays low
    property p_rfs;
        (i_ultra && !i_dir_in && !o_dmack_n && !i_iordy) [*5] |-> $stable(o_hstrobe);
    endproperty
    a_rfs: assert property (p_rfs) else $error("strobe while paused");
    // Bus released within three cycles of ack end
    property p_rel;
        $rose(o_dmack_n) |-> ##[0:3] !o_dd_oe;
    endproperty
    a_rel: assert property (p_rel) else $error("bus not released");
    // Released bus stays released one cycle
    property p_zah;
        $fell(o_dd_oe) |=> !o_dd_oe;
    endproperty
    a_zah: assert property (p_zah) else $error("bus driven too soon");
    c_hstrobe: cover property ($rose(o_hstrobe));
    c_uin: cover property ($fell(o_dmack_n) && i_ultra && i_dir_in);
    c_mw_end: cover property ($rose(o_dmack_n) && !i_ultra);
endmodule // dbh_properties
`default_nettype wire

// File: verification/dbh_dev_model.sv
// Device model answering the DMA burst handshake
`timescale 1ns/1ps
`default_nettype none
module dbh_dev_model (
    input wire logic i_dmack_n,
    input wire logic i_dior_n,
    input wire logic i_diow_n,
    input wire logic i_hstrobe,
    input wire logic i_ultra,
    input wire logic i_dir_in,
    input wire logic i_go,
    input wire logic [7:0] i_words,
    input wire logic [7:0] i_pause_at,
    input wire logic [15:0] i_dd_host,
    output logic o_dmarq,
    output logic o_iordy,
    output logic [15:0] o_dd,
    output logic o_dd_oe
);
    localparam logic [15:0] BASE = 16'h3C00; // First word sent
    logic [15:0] rx_q[$]; // Words taken from host
    logic [7:0] cnt = 8'h00; // Words moved this burst
    logic rdy = 1'b1; // Device ready or device strobe
    wire acked = !i_dmack_n;
    initial begin
        o_dmarq = 1'b0;
        o_dd = BASE;
        o_dd_oe = 1'b0;
    end
    // Released ready line floats to the pull-up level
    assign o_iordy = (acked && i_ultra) ? rdy : 1'b1;
    // Fresh request per burst, mode 0 multiword unless told Ultra
    always @(posedge i_go) begin
        cnt = 8'h00;
        rdy = 1'b1;
        o_dmarq = 1'b1;
    end
    // Host ended: drop request after ack seen negated
    always @(posedge i_dmack_n) begin
        o_dd_oe = 1'b0;
        if (!i_go) o_dmarq = 1'b0;
    end
    // Pulse start: last word drops request at once
    always @(negedge i_dior_n or negedge i_diow_n) if (acked && !i_ultra) begin
        if (i_words != 8'h00 && cnt + 8'h01 >= i_words) o_dmarq = 1'b0;
        if (!i_dior_n) begin
            o_dd = BASE + {8'h00, cnt};
            o_dd_oe = 1'b1;
        end
    end
    // Word moves at pulse negation
    always @(posedge i_dior_n or posedge i_diow_n) if (acked && !i_ultra) begin
        if (!i_dir_in) rx_q.push_back(i_dd_host);
        cnt = cnt + 8'h01;
    end
    // Ultra data-out: one word per host strobe edge
    always @(i_hstrobe) if (acked && i_ultra && !i_dir_in && !i_diow_n) begin
        #20 rx_q.push_back(i_dd_host);
        cnt = cnt + 8'h01;
    end
    // Pause once, keep taking words in flight
    always @(cnt) if (acked && i_ultra && !i_dir_in && cnt == i_pause_at) begin
        #30 rdy = 1'b0;
        #1000 rdy = 1'b1;
    end
    // Stop asserted in data-in: give the bus back
    always @(posedge i_diow_n) if (acked && i_ultra) begin
        o_dd_oe = 1'b0;
        // Data-out: answer stop by dropping the request
        if (!i_dir_in) #60 o_dmarq = 1'b0;
    end
    // Ultra data-in: paced strobe, waits on host ready
    always @(negedge i_diow_n) if (acked && i_ultra && i_dir_in) begin
        o_dd_oe = 1'b1;
        while (!i_dmack_n && cnt < i_words) begin
            o_dd = BASE + {8'h00, cnt};
            #63;
            wait (!i_dior_n || i_dmack_n);
            rdy = ~rdy;
            cnt = cnt + 8'h01;
            #337;
        end
        #100 o_dmarq = 1'b0;
    end
endmodule // dbh_dev_model
`default_nettype wire

// File: verification/dma_burst_handshake_tb.sv
// Testbench of the DMA burst host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
        fail_count++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
end
module dma_burst_handshake_tb;
    logic clk, rst, start, ultra, dir_in, stop, out_valid, in_ready, go;
    logic out_ready, in_valid, busy, dmarq, iordy, dd_oe, dev_oe, dmack_n, dior_n, diow_n, hstb;
    logic [15:0] out_data, in_data, dd_host, dev_dd, base;
    logic [7:0] words, pause_at;
    logic [15:0] rd_q[$]; // Words handed to the user
    int fail_count, total_checks;
    // Released bus shows the inverse of the last device word
    wire logic [15:0] bus_dd = dev_oe ? dev_dd : (dd_oe ? dd_host : ~dev_dd);
    dbh_host dut (.i_clk_sys(clk), .i_reset(rst), .i_start(start), .i_ultra(ultra),
        .i_dir_in(dir_in), .i_stop(stop), .i_out_valid(out_valid), .i_out_data(out_data),
        .o_out_ready(out_ready), .o_in_valid(in_valid), .o_in_data(in_data),
        .i_in_ready(in_ready), .o_busy(busy), .i_dmarq(dmarq), .i_iordy(iordy),
        .i_dd(bus_dd), .o_dd(dd_host), .o_dd_oe(dd_oe), .o_dmack_n(dmack_n),
        .o_dior_n(dior_n), .o_diow_n(diow_n), .o_hstrobe(hstb));
    dbh_dev_model dev (.i_dmack_n(dmack_n), .i_dior_n(dior_n), .i_diow_n(diow_n),
        .i_hstrobe(hstb), .i_ultra(ultra), .i_dir_in(dir_in), .i_go(go), .i_words(words),
        .i_pause_at(pause_at), .i_dd_host(dd_host), .o_dmarq(dmarq), .o_iordy(iordy),
        .o_dd(dev_dd), .o_dd_oe(dev_oe));
    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Next write word once the current one is taken
    always @(posedge clk) if (out_ready === 1'b1) out_data <= out_data + 16'h0001;
    // Collect read words handed over
    always @(posedge clk) if (in_valid === 1'b1 && in_ready === 1'b1) rd_q.push_back(in_data);
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Raise the request, then pulse start
    task automatic begin_burst(input logic u, input logic d,
        input logic [7:0] w, input logic [7:0] p);
        @(posedge clk);
        ultra <= u;
        dir_in <= d;
        words <= w;
        pause_at <= p;
        go <= 1'b1;
        base <= out_data;
        repeat (4) @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask
    // Bounded wait for the burst to finish
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) @(posedge clk);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        repeat (6) @(posedge clk);
        `CHK("busy", 1'b0, busy)
        `CHK("dmack_n", 1'b1, dmack_n)
    endtask
    // Bounded wait until the device has moved n words
    task automatic wait_words(input logic [7:0] n);
        int k;
        k = 0;
        while (dev.cnt < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
    endtask
    // Multiword write ended by the device after three words
    task automatic t_mw_write();
        dev.rx_q.delete();
        begin_burst(1'b0, 1'b0, 8'h03, 8'hFF);
        wait_idle();
        go <= 1'b0;
        `CHK("mw words", 3, dev.rx_q.size())
        for (int i = 0; i < dev.rx_q.size(); i++) begin
            `CHK("mw wr", base + 16'(i), dev.rx_q[i])
        end
    endtask
    // Multiword read ended by the host mid-stream
    task automatic t_mw_read_stop();
        rd_q.delete();
        begin_burst(1'b0, 1'b1, 8'h00, 8'hFF);
        wait_words(8'h02);
        stop <= 1'b1;
        go <= 1'b0;
        wait_idle();
        stop <= 1'b0;
        `CHK("mw rd cnt", 32'(dev.cnt), rd_q.size())
        for (int i = 0; i < rd_q.size(); i++) `CHK("mw rd", 16'h3C00 + 16'(i), rd_q[i])
    endtask
    // Ultra write with a device pause, ended by stop
    task automatic t_udma_out();
        dev.rx_q.delete();
        begin_burst(1'b1, 1'b0, 8'h00, 8'h03);
        wait_words(8'h08);
        stop <= 1'b1;
        go <= 1'b0;
        wait_idle();
        stop <= 1'b0;
        `CHK("u wr cnt", 32'(out_data - base), dev.rx_q.size())
        for (int i = 0; i < dev.rx_q.size(); i++) begin
            `CHK("u wr", base + 16'(i), dev.rx_q[i])
        end
    endtask
    // Ultra read of eight words while the user stalls
    task automatic t_udma_in();
        rd_q.delete();
        in_ready <= 1'b0;
        begin_burst(1'b1, 1'b1, 8'h08, 8'hFF);
        repeat (40) @(posedge clk);
        in_ready <= 1'b1;
        wait_idle();
        go <= 1'b0;
        `CHK("u rd cnt", 8, rd_q.size())
        for (int i = 0; i < rd_q.size(); i++) `CHK("u rd", 16'h3C00 + 16'(i), rd_q[i])
    endtask
    // Start without a request is ignored
    task automatic t_refused();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK("busy idle", 1'b0, busy)
        `CHK("ack idle", 1'b1, dmack_n)
    endtask
    // Main sequence
    initial begin
        {rst, start, ultra, dir_in, stop, go} = 6'h20;
        {out_valid, in_ready} = 2'h3;
        out_data = 16'hA500;
        base = 16'hA500;
        words = 8'h00;
        pause_at = 8'hFF;
        fail_count = 0;
        total_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_refused();
        t_mw_write();
        t_mw_read_stop();
        t_udma_out();
        t_udma_in();
        summarize();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule // dma_burst_handshake_tb
bind dbh_host dbh_properties u_props (.i_clk_sys, .i_reset, .i_ultra, .i_dir_in, .i_iordy,
    .o_dd, .o_dd_oe, .o_dmack_n, .o_dior_n, .o_diow_n, .o_hstrobe);
`default_nettype wire
